// ==== verilog/dinfo_map.svh ====
// Purpose: Address map and constants of the device information area
// Assumes: 14-bit program words, 16-bit program addresses
// Notes:   Included by the design files
`ifndef DINFO_MAP_SVH
`define DINFO_MAP_SVH
`define DINFO_BASE       16'h8100
`define DINFO_FUID_FIRST 16'h8100
`define DINFO_FUID_LAST  16'h8109
`define DINFO_CUID_FIRST 16'h810a
`define DINFO_CUID_LAST  16'h8111
`define DINFO_TLOW_FIRST 16'h8112
`define DINFO_TLOW_LAST  16'h8114
`define DINFO_THIGH_FIRST 16'h8115
`define DINFO_THIGH_LAST 16'h8117
`define DINFO_DEPTH      24
`define DINFO_IDX_W      5
`define DINFO_WORD_W     14
`define DINFO_ADC_W      10
`define DINFO_VREF_MV    2048
`define DINFO_VDD_MV     3000
`define DINFO_ZERO_WORD  14'h0000
`endif

// ==== verilog/dinfo_pkg.sv ====
// Purpose: Types of the device information area
// Assumes: Constants come from dinfo_map.svh
// Notes:   No imports; use dinfo_pkg::name
`include "dinfo_map.svh"
package dinfo_pkg;
	typedef logic [`DINFO_WORD_W-1:0] dinfo_word_t;
	typedef logic [`DINFO_IDX_W-1:0]  dinfo_idx_t;
	typedef enum logic [1:0] {
		DINFO_ZONE_FUID,
		DINFO_ZONE_CUID,
		DINFO_ZONE_TLOW,
		DINFO_ZONE_THIGH
	} dinfo_zone_t;
endpackage

// ==== verilog/dinfo_rd_if.sv ====
// Purpose: Read port between the area top and its memory
// Assumes: One clock, read data registered in the memory
// Notes:   No write signals exist on purpose
`timescale 1ns/1ps
`default_nettype none
`include "dinfo_map.svh"
interface dinfo_rd_if;
	logic                 en;
	dinfo_pkg::dinfo_idx_t  idx;
	dinfo_pkg::dinfo_word_t data;
	modport master (output en, output idx, input data);
	modport slave  (input en, input idx, output data);
endinterface
`default_nettype wire

// ==== verilog/dinfo_rom.sv ====
// Purpose: Factory-programmed word store of the information area
// Assumes: Contents fixed at manufacture through parameter
// Notes:   Read-only; there is no write port at all
`timescale 1ns/1ps
`default_nettype none
`include "dinfo_map.svh"
module dinfo_rom #(
	parameter int DEPTH = `DINFO_DEPTH,
	parameter logic [`DINFO_DEPTH*`DINFO_WORD_W-1:0] CONTENTS = '0
) (
	input  wire logic  clock_i,
	input  wire logic  rstn_i,
	dinfo_rd_if.slave  rd
);
	dinfo_pkg::dinfo_word_t data_q;
	dinfo_pkg::dinfo_word_t data_d;
	wire logic              idx_ok;

	// The packed contents are laid out for the full map only
	if (DEPTH != `DINFO_DEPTH) begin : g_depth_bad
		$error("dinfo_rom depth must match the area map");
	end

	assign idx_ok = int'(rd.idx) < DEPTH;
	// Constant contents, so no erase or write can alter them
	assign data_d = idx_ok ? CONTENTS[rd.idx*`DINFO_WORD_W +: `DINFO_WORD_W] : `DINFO_ZERO_WORD;

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			data_q <= `DINFO_ZERO_WORD;
		end else if (rd.en) begin
			data_q <= data_d;
		end
	end
	assign rd.data = data_q;
endmodule // dinfo_rom
`default_nettype wire

// ==== verilog/dinfo_area.sv ====
// Purpose: Read-only device information area in program space
// Assumes: Core read path gives address and strobe; one cycle latency
// Notes:   Writes and row erases are accepted and dropped
`timescale 1ns/1ps
`default_nettype none
`include "dinfo_map.svh"
module dinfo_area #(
	parameter logic [`DINFO_DEPTH*`DINFO_WORD_W-1:0] CONTENTS = '0,
	parameter int VREF_MV = `DINFO_VREF_MV
) (
	input  wire logic                        clock_i,
	input  wire logic                        rstn_i,
	input  wire logic                        rd_en_i,
	input  wire logic [15:0]                 addr_i,
	input  wire logic                        wr_en_i,
	input  wire logic                        erase_en_i,
	input  wire logic                        bulk_erase_i,
	output logic      [`DINFO_WORD_W-1:0]    rd_data_o,
	output logic                             rd_valid_o,
	output logic                             hit_o,
	output logic                             wr_block_o,
	output logic      [1:0]                  zone_o
);
	dinfo_rd_if rd ();
	logic                 valid_q;
	logic                 hit_q;
	logic [1:0]           zone_q;
	wire logic            in_area;
	wire logic [15:0]     offs;
	dinfo_pkg::dinfo_zone_t zone_d;
	localparam int CAL_FIRST = int'(`DINFO_TLOW_FIRST - `DINFO_BASE);
	localparam int CAL_LAST  = int'(`DINFO_THIGH_LAST - `DINFO_BASE);
	localparam int CAL_PAD   = `DINFO_WORD_W - `DINFO_ADC_W;

	// Stored codes are only meaningful against this reference
	if (VREF_MV != `DINFO_VREF_MV) begin : g_vref_bad
		$error("calibration words assume the 2048 mV reference");
	end

	// Right-justified codes leave the top bits of the word clear
	for (genvar g = CAL_FIRST; g <= CAL_LAST; g++) begin : g_cal_chk
		if (CONTENTS[g*`DINFO_WORD_W+`DINFO_ADC_W +: CAL_PAD] != '0) begin : g_cal_bad
			$error("calibration word wider than the converter");
		end
	end

	function automatic logic in_span(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_span = (a >= lo) && (a <= hi);
	endfunction

	assign in_area = in_span(addr_i, `DINFO_FUID_FIRST, `DINFO_THIGH_LAST);
	assign offs    = addr_i - `DINFO_BASE;
	assign zone_d  = in_span(addr_i, `DINFO_FUID_FIRST, `DINFO_FUID_LAST) ? dinfo_pkg::DINFO_ZONE_FUID :
	                 in_span(addr_i, `DINFO_CUID_FIRST, `DINFO_CUID_LAST) ? dinfo_pkg::DINFO_ZONE_CUID :
	                 in_span(addr_i, `DINFO_TLOW_FIRST, `DINFO_TLOW_LAST) ? dinfo_pkg::DINFO_ZONE_TLOW :
	                 dinfo_pkg::DINFO_ZONE_THIGH;

	// Only reads reach the store; write and erase strobes have no path
	assign rd.en  = rd_en_i && in_area;
	assign rd.idx = offs[`DINFO_IDX_W-1:0];

	dinfo_rom #(
		.DEPTH    (`DINFO_DEPTH),
		.CONTENTS (CONTENTS) // Factory data incl. customer words
	) u_rom (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.rd      (rd.slave)
	);

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			valid_q <= 1'b0;
			hit_q   <= 1'b0;
			zone_q  <= 2'h0;
		end else begin
			valid_q <= rd_en_i;
			hit_q   <= rd.en;
			zone_q  <= zone_d;
		end
	end

	// Outside reads answer zero rather than stale data
	assign rd_data_o  = hit_q ? rd.data : `DINFO_ZERO_WORD;
	assign rd_valid_o = valid_q;
	assign hit_o      = hit_q;
	assign zone_o     = zone_q;
	// Flags attempts that were dropped, for the memory controller
	assign wr_block_o = (wr_en_i || erase_en_i || bulk_erase_i) && in_area;

	property p_read_latency;
		@(posedge clock_i) disable iff (!rstn_i)
		rd_en_i |=> rd_valid_o;
	endproperty
	a_read_latency: assert property (p_read_latency) else $error("read not answered");

	property p_hit_match;
		@(posedge clock_i) disable iff (!rstn_i)
		(rd_en_i && in_area) |=> hit_o;
	endproperty
	a_hit_match: assert property (p_hit_match) else $error("area read missed");

	property p_miss_zero;
		@(posedge clock_i) disable iff (!rstn_i)
		(rd_en_i && !in_area) |=> (rd_data_o == `DINFO_ZERO_WORD);
	endproperty
	a_miss_zero: assert property (p_miss_zero) else $error("outside read not zero");

	property p_stable_write;
		@(posedge clock_i) disable iff (!rstn_i)
		(rd_en_i && in_area && (wr_en_i || bulk_erase_i)) ##1 (rd_en_i && $stable(addr_i))
		|=> $stable(rd_data_o);
	endproperty
	a_stable_write: assert property (p_stable_write) else $error("write altered data");

	property p_block_flag;
		@(posedge clock_i) disable iff (!rstn_i)
		(in_area && erase_en_i) |-> wr_block_o;
	endproperty
	a_block_flag: assert property (p_block_flag) else $error("erase not blocked");

	property p_zone_cuid;
		@(posedge clock_i) disable iff (!rstn_i)
		(addr_i == `DINFO_CUID_FIRST) |=> (zone_o == 2'h1);
	endproperty
	a_zone_cuid: assert property (p_zone_cuid) else $error("customer zone wrong");

	property p_zone_low;
		@(posedge clock_i) disable iff (!rstn_i)
		(addr_i == `DINFO_TLOW_LAST) |=> (zone_o == 2'h2);
	endproperty
	a_zone_low: assert property (p_zone_low) else $error("low range zone wrong");

	property p_zone_high;
		@(posedge clock_i) disable iff (!rstn_i)
		(addr_i == `DINFO_THIGH_FIRST) |=> (zone_o == 2'h3);
	endproperty
	a_zone_high: assert property (p_zone_high) else $error("high range zone wrong");

	property p_zone_fuid;
		@(posedge clock_i) disable iff (!rstn_i)
		(rstn_i && addr_i == `DINFO_FUID_FIRST) |=> (zone_o == dinfo_pkg::DINFO_ZONE_FUID);
	endproperty
	a_zone_fuid: assert property (p_zone_fuid) else $error("factory zone wrong");

	property p_zone_fuid_end;
		@(posedge clock_i) disable iff (!rstn_i)
		(rstn_i && addr_i == `DINFO_FUID_LAST) |=> (zone_o == dinfo_pkg::DINFO_ZONE_FUID);
	endproperty
	a_zone_fuid_end: assert property (p_zone_fuid_end) else $error("factory zone end wrong");

	property p_zone_cuid_end;
		@(posedge clock_i) disable iff (!rstn_i)
		(rstn_i && addr_i == `DINFO_CUID_LAST) |=> (zone_o == dinfo_pkg::DINFO_ZONE_CUID);
	endproperty
	a_zone_cuid_end: assert property (p_zone_cuid_end) else $error("customer zone end wrong");

	property p_zone_low_first;
		@(posedge clock_i) disable iff (!rstn_i)
		(rstn_i && addr_i == `DINFO_TLOW_FIRST) |=> (zone_o == dinfo_pkg::DINFO_ZONE_TLOW);
	endproperty
	a_zone_low_first: assert property (p_zone_low_first) else $error("low zone start wrong");

	property p_zone_high_end;
		@(posedge clock_i) disable iff (!rstn_i)
		(rstn_i && addr_i == `DINFO_THIGH_LAST) |=> (zone_o == dinfo_pkg::DINFO_ZONE_THIGH);
	endproperty
	a_zone_high_end: assert property (p_zone_high_end) else $error("high zone end wrong");

	property p_zone_outside;
		@(posedge clock_i) disable iff (!rstn_i)
		(rstn_i && !in_area) |=> (zone_o == dinfo_pkg::DINFO_ZONE_THIGH);
	endproperty
	a_zone_outside: assert property (p_zone_outside) else $error("outside zone wrong");

	property p_valid_idle;
		@(posedge clock_i) disable iff (!rstn_i)
		!rd_en_i |=> !rd_valid_o;
	endproperty
	a_valid_idle: assert property (p_valid_idle) else $error("answer without read");

	property p_hit_idle;
		@(posedge clock_i) disable iff (!rstn_i)
		!(rd_en_i && in_area) |=> !hit_o;
	endproperty
	a_hit_idle: assert property (p_hit_idle) else $error("hit without area read");

	property p_idle_zero;
		@(posedge clock_i) disable iff (!rstn_i)
		!hit_o |-> (rd_data_o == `DINFO_ZERO_WORD);
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("stale data shown");

	property p_cal_justified;
		@(posedge clock_i) disable iff (!rstn_i)
		(hit_o && (zone_o == dinfo_pkg::DINFO_ZONE_TLOW ||
			zone_o == dinfo_pkg::DINFO_ZONE_THIGH))
		|-> (rd_data_o[`DINFO_WORD_W-1:`DINFO_ADC_W] == '0);
	endproperty
	a_cal_justified: assert property (p_cal_justified) else $error("code not justified");

	property p_block_write;
		@(posedge clock_i) disable iff (!rstn_i)
		(in_area && (wr_en_i || bulk_erase_i)) |-> wr_block_o;
	endproperty
	a_block_write: assert property (p_block_write) else $error("write not blocked");

	property p_stable_erase;
		@(posedge clock_i) disable iff (!rstn_i)
		(rd_en_i && in_area && erase_en_i) ##1 (rd_en_i && $stable(addr_i))
		|=> $stable(rd_data_o);
	endproperty
	a_stable_erase: assert property (p_stable_erase) else $error("erase altered data");

	property p_repeat_read;
		@(posedge clock_i) disable iff (!rstn_i)
		(rd_en_i && in_area) ##1 (rd_en_i && $stable(addr_i))
		|=> $stable(rd_data_o);
	endproperty
	a_repeat_read: assert property (p_repeat_read) else $error("repeat read differs");
endmodule // dinfo_area
`default_nettype wire

// ==== dv/test_device_info_area_readonly.sv ====
// Purpose: Self-checking bench of the device information area
// Assumes: Fixed one-cycle read latency, sync active-low reset
// Notes:   Customer words left unprogrammed, as shipped by default
`timescale 1ns/1ps
`default_nettype none
`include "dinfo_map.svh"
module test_device_info_area_readonly;
	logic        clock_i, rstn_i, rd_en_i, wr_en_i, erase_en_i, bulk_erase_i;
	logic [15:0] addr_i;
	logic [13:0] rd_data_o;
	logic        rd_valid_o, hit_o, wr_block_o;
	logic [1:0]  zone_o;
	int          fails, comparisons;

	// Id words full width, calibration words 10 bits right-justified
	function automatic logic [13:0] word_of(int i);
		if (i < 10) return 14'h3a00 | 14'(i);
		if (i < 18) return 14'h0000;
		return 14'h0200 | 14'(i);
	endfunction
	function automatic logic [`DINFO_DEPTH*14-1:0] pack();
		logic [`DINFO_DEPTH*14-1:0] v;
		for (int i = 0; i < `DINFO_DEPTH; i++) v[14*i +: 14] = word_of(i);
		return v;
	endfunction
	function automatic logic [1:0] zone_of(int k);
		if (k < 0 || k > 23) return 2'h3;
		if (k < 10) return 2'h0;
		if (k < 18) return 2'h1;
		return (k < 21) ? 2'h2 : 2'h3;
	endfunction
	localparam logic [`DINFO_DEPTH*14-1:0] CONTENTS = pack();

	dinfo_area #(.CONTENTS(CONTENTS), .VREF_MV(2048)) dut_u (
		.clock_i(clock_i), .rstn_i(rstn_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
		.wr_en_i(wr_en_i), .erase_en_i(erase_en_i), .bulk_erase_i(bulk_erase_i),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .hit_o(hit_o),
		.wr_block_o(wr_block_o), .zone_o(zone_o));

	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic reset_pulse(input int n);
		@(posedge clock_i);
		rstn_i <= 1'b0;
		repeat (n) @(posedge clock_i);
		#1;
		chk("rst valid", 14'h0, {13'h0, rd_valid_o});
		chk("rst hit", 14'h0, {13'h0, hit_o});
		chk("rst data", 14'h0, rd_data_o);
		chk("rst zone", 14'h0, {12'h0, zone_o});
		@(posedge clock_i);
		rstn_i <= 1'b1;
	endtask

	// Back to back, one word below and one above the area
	task automatic read_sweep();
		int  k;
		logic in;
		for (int j = 0; j <= 26; j++) begin
			@(posedge clock_i);
			rd_en_i <= (j < 26);
			addr_i <= 16'h80ff + 16'(j);
			#1;
			if (j > 0) begin
				k = j - 2;
				in = (k >= 0 && k < 24);
				chk("valid", 14'h1, {13'h0, rd_valid_o});
				chk("hit", 14'(in), {13'h0, hit_o});
				chk("data", in ? word_of(k) : 14'h0, rd_data_o);
				chk("zone", 14'(zone_of(k)), {12'h0, zone_o});
			end
		end
		@(posedge clock_i);
		#1;
		chk("valid end", 14'h0, {13'h0, rd_valid_o});
	endtask

	// Write, row erase and bulk erase aimed inside and outside, read meanwhile
	task automatic write_attempts();
		logic [15:0] a;
		for (int s = 0; s < 3; s++) begin
			for (int o = 0; o < 2; o++) begin
				a = o ? 16'h8118 : 16'h8100 + 16'(s * 9);
				@(posedge clock_i);
				addr_i <= a;
				rd_en_i <= 1'b1;
				wr_en_i <= (s == 0);
				erase_en_i <= (s == 1);
				bulk_erase_i <= (s == 2);
				repeat (2) begin
					#1;
					chk("block", 14'(o == 0), {13'h0, wr_block_o});
					@(posedge clock_i);
				end
				#1;
				chk("kept", o ? 14'h0 : word_of(int'(a - 16'h8100)), rd_data_o);
			end
		end
		@(posedge clock_i);
		rd_en_i <= 1'b0;
		wr_en_i <= 1'b0;
		erase_en_i <= 1'b0;
		bulk_erase_i <= 1'b0;
		#1;
		chk("block idle", 14'h0, {13'h0, wr_block_o});
	endtask

	initial begin
		repeat (100000) @(posedge clock_i);
		fails++;
		report_and_stop();
	end

	initial begin
		{rstn_i, rd_en_i, wr_en_i, erase_en_i, bulk_erase_i} = 5'h0;
		addr_i = 16'h0000;
		fails = 0;
		comparisons = 0;
		reset_pulse(20);
		read_sweep();
		write_attempts();
		read_sweep();
		reset_pulse(3);
		read_sweep();
		report_and_stop();
	end
endmodule // test_device_info_area_readonly
`default_nettype wire
